// ==== core/vllc_map.svh ====
// offsets-free constant map: timing figures and cycle counts for the light-load controller
`ifndef VLLC_MAP_SVH
`define VLLC_MAP_SVH
// internal clock period in ns (20 MHz)
`define VLLC_CLK_NS 50
// least time -> round up, longest time -> round down, never below one cycle
`define VLLC_CYC_UP(ns) ((((ns) + `VLLC_CLK_NS - 1) / `VLLC_CLK_NS) < 1 ? 1 : \
	(((ns) + `VLLC_CLK_NS - 1) / `VLLC_CLK_NS))
`define VLLC_CYC_DN(ns) (((ns) / `VLLC_CLK_NS) < 1 ? 1 : ((ns) / `VLLC_CLK_NS))
// steady valley timeout, 6 us
`define VLLC_TOUT_STEADY_NS 6000
`define VLLC_TOUT_STEADY_CYC `VLLC_CYC_DN(`VLLC_TOUT_STEADY_NS)
// soft-start valley timeout, 100 us
`define VLLC_TOUT_START_NS 100000
`define VLLC_TOUT_START_CYC `VLLC_CYC_DN(`VLLC_TOUT_START_NS)
// longest switching period before a forced cycle, 40 us
`define VLLC_MIN_FREQ_NS 40000
`define VLLC_MIN_FREQ_CYC `VLLC_CYC_DN(`VLLC_MIN_FREQ_NS)
// max frequency clamp, 110 kHz -> least period in ns
`define VLLC_MAX_FREQ_SET_PIN_KHZ 110
`define VLLC_MAX_FREQ_SET_PIN_NS (1000000 / `VLLC_MAX_FREQ_SET_PIN_KHZ)
`define VLLC_MAX_FREQ_SET_PIN_CYC `VLLC_CYC_UP(`VLLC_MAX_FREQ_SET_PIN_NS)
// foldback dead-time at full depth, 32 us
`define VLLC_DEADTIME_NS 32000
`define VLLC_DEADTIME_CYC `VLLC_CYC_UP(`VLLC_DEADTIME_NS)
// quiet timer, 1250 us minimum
`define VLLC_QUIET_NS 1250000
`define VLLC_QUIET_CYC `VLLC_CYC_UP(`VLLC_QUIET_NS)
// burst minimum pulse count, valley count, reset valley
`define VLLC_BURST_PULSES 3
`define VLLC_VALLEYS 6
`define VLLC_VALLEY_RST 1
`endif

// ==== core/vllc_pkg.sv ====
// types shared by the light-load controller files
package vllc_pkg;
	// switching cycle phase
	typedef enum logic [1:0] {
		VLLC_C_ON = 2'b00,
		VLLC_C_OFF = 2'b01,
		VLLC_C_DEAD = 2'b10,
		VLLC_C_WAIT = 2'b11
	} vllc_cyc_t;
	// quiet-skip burst phase
	typedef enum logic [1:0] {
		VLLC_B_OFF = 2'b00,
		VLLC_B_STOP = 2'b01,
		VLLC_B_RUN = 2'b10
	} vllc_burst_t;
endpackage

// ==== core/vllc_tmr_if.sv ====
// timer hookup between the controller and its one-shot timers
`timescale 1ns/1ps
interface vllc_tmr_if #(parameter int W = 16);
	logic start; // one-cycle load strobe
	logic [W-1:0] load; // cycles to run
	logic expired; // level, high once run out (and after reset)
	logic fire; // one-cycle pulse at run-out
	modport ctrl (output start, output load, input expired, input fire);
	modport tmr (input start, input load, output expired, output fire);
endinterface

// ==== core/vllc_timer.sv ====
// one-shot down timer with expiry level and pulse
`timescale 1ns/1ps
module vllc_timer #(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic reset_i,
	vllc_tmr_if.tmr t
);
	logic [W-1:0] cnt_reg; // remaining cycles
	logic run_reg; // counting
	logic exp_reg; // expired level
	logic fire_reg; // run-out pulse

	// elaboration guard: the run-out test needs at least two bits of count
	if (W < 2)
		$error("vllc_timer: W too small");

	////////////////////////////////////////////////////////////////////////////////
	// counting: a fresh start always wins over a run-out in the same cycle
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
			exp_reg <= 1'b1; // idle timer reads as expired
			fire_reg <= 1'b0;
		end
		else if (t.start)
		begin
			cnt_reg <= t.load;
			run_reg <= 1'b1;
			exp_reg <= 1'b0;
			fire_reg <= 1'b0;
		end
		else if (run_reg && cnt_reg <= W'(1))
		begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
			exp_reg <= 1'b1;
			fire_reg <= 1'b1;
		end
		else
		begin
			cnt_reg <= run_reg ? cnt_reg - W'(1) : cnt_reg;
			fire_reg <= 1'b0;
		end
	end

	assign t.expired = exp_reg;
	assign t.fire = fire_reg;
endmodule // vllc_timer

// ==== core/vllc_ctrl.sv ====
// valley lockout, foldback, min/max frequency and quiet-skip gate drive control
`timescale 1ns/1ps
`include "vllc_map.svh"
module vllc_ctrl #(
	parameter int QUIET_CYC = `VLLC_QUIET_CYC, // quiet timer length, shortenable
	parameter int TW = 16 // timer width
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic max_freq_set_pin_disable_i, // max_freq_set_pin above 4 V
	input wire logic demag_sense_i, // demag_sense below trigger level
	input wire logic cs_trip_i, // peak current reached, ends pulse
	input wire logic soft_start_i, // soft-start ramp active
	input wire logic [4:0] fb_below_fall_i, // feedback_level below falling thresholds
	input wire logic [4:0] fb_above_rise_i, // feedback_level above rising thresholds
	input wire logic fb_below_ff_i, // feedback_level below 0.6 V
	input wire logic fb_above_ramp_i, // feedback_level above dead-time ramp
	input wire logic fb_below_skip_i, // feedback_level below skip level
	input wire logic fb_above_skip_exit_i, // above skip plus skip_exit_hysteresis
	input wire logic fb_above_burst_exit_i, // feedback_level above 800 mV
	output logic gate_drive_o, // gate_drive
	output logic [2:0] valley_sel_o, // selected valley 1..6
	output logic foldback_mode_o, // foldback_mode active
	output logic peak_freeze_o, // peak setpoint frozen at 0.2 V
	output logic burst_mode_o, // quiet-skip burst mode
	output logic [9:0] dt_ramp_o // dead-time ramp code, 0 = 0.6 V
);
	localparam logic [2:0] VALLEY_MAX = 3'(`VLLC_VALLEYS);
	localparam logic [2:0] VALLEY_RST = 3'(`VLLC_VALLEY_RST);
	localparam logic [9:0] MINF_CYC = 10'(`VLLC_MIN_FREQ_CYC);
	localparam logic [9:0] MAX_FREQ_SET_PIN_CYC = 10'(`VLLC_MAX_FREQ_SET_PIN_CYC);
	localparam logic [9:0] DT_CYC = 10'(`VLLC_DEADTIME_CYC);
	localparam logic [1:0] BURST_N = 2'(`VLLC_BURST_PULSES);
	localparam logic [TW-1:0] TOUT_ST = TW'(`VLLC_TOUT_STEADY_CYC);
	localparam logic [TW-1:0] TOUT_SS = TW'(`VLLC_TOUT_START_CYC);

	// elaboration guards: the timers must hold the longest load
	if (QUIET_CYC < 2 || QUIET_CYC >= (1 << TW))
		$error("vllc_ctrl: QUIET_CYC does not fit the timer");
	if (`VLLC_TOUT_START_CYC >= (1 << TW))
		$error("vllc_ctrl: timeout does not fit the timer");
	vllc_pkg::vllc_cyc_t state_reg; // cycle phase
	vllc_pkg::vllc_burst_t bstate_reg; // burst phase
	vllc_pkg::vllc_burst_t bstate_next;
	logic [2:0] sel_reg; // selected valley
	logic [2:0] vcnt_reg; // valleys counted this off-time
	logic ff_reg; // foldback active
	logic gate_reg; // gate drive
	logic burst_reg; // burst output copy
	logic demag_q_reg; // last demag level, for edge
	logic demag_done_reg; // a true demag seen since turn-off
	logic [9:0] per_reg; // cycles since last turn-on, saturating
	logic [9:0] dt_reg; // dead-time elapsed
	logic [1:0] bcnt_reg; // burst pulses, saturating at 3
	logic stop_pend_reg; // skip-in seen during burst run
	logic demag_evt; // demag trigger edge
	logic valley_evt; // valley or timeout substitute
	logic minf_hit; // 40 us period reached
	logic burst_allow; // burst control lets a pulse start
	logic start_ok; // pulse may start this cycle
	logic start_evt; // pulse starts this cycle
	logic off_evt; // pulse ends this cycle
	vllc_tmr_if #(.W(TW)) tout ();
	vllc_tmr_if #(.W(TW)) quiet ();
	vllc_timer #(.W(TW)) u_tout (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.t(tout)
	);
	vllc_timer #(.W(TW)) u_quiet (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.t(quiet)
	);
	////////////////////////////////////////////////////////////////////////////////
	// event decode; comparators are already on this clock, so no synchroniser
	assign demag_evt = demag_sense_i && !demag_q_reg;
	// a timeout only counts while waiting in the off-time
	assign valley_evt = (state_reg == vllc_pkg::VLLC_C_OFF) &&
		(demag_evt || tout.fire);
	assign minf_hit = per_reg >= MINF_CYC - 10'(1);
	assign off_evt = (state_reg == vllc_pkg::VLLC_C_ON) && cs_trip_i;

	// burst gating only blocks new starts, so a running pulse always completes
	always_comb
	begin
		case (bstate_reg)
			vllc_pkg::VLLC_B_OFF: burst_allow = !fb_below_skip_i;
			vllc_pkg::VLLC_B_RUN: burst_allow = !(stop_pend_reg && bcnt_reg == BURST_N);
			default: burst_allow = 1'b0; // stopped burst
		endcase
	end

	// the clamp is measured turn-on to turn-on
	assign start_ok = burst_allow && (max_freq_set_pin_disable_i || per_reg >= MAX_FREQ_SET_PIN_CYC);
	assign start_evt = (state_reg == vllc_pkg::VLLC_C_WAIT) && start_ok;
	////////////////////////////////////////////////////////////////////////////////
	// valley timeout restarts at turn-off, and in the off-time on every demag edge and on itself
	always_comb
	begin
		tout.start = off_evt || valley_evt;
		tout.load = soft_start_i ? TOUT_SS : TOUT_ST;
	end

	// quiet timer starts when a burst resumes on skip exit
	always_comb
	begin
		quiet.start = (bstate_reg == vllc_pkg::VLLC_B_STOP) &&
			(bstate_next == vllc_pkg::VLLC_B_RUN);
		quiet.load = TW'(QUIET_CYC);
	end
	////////////////////////////////////////////////////////////////////////////////
	// valley selection with hysteresis; one step per clock keeps it monotonic
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			sel_reg <= VALLEY_RST;
		else if (sel_reg < VALLEY_MAX && fb_below_fall_i[sel_reg - 3'(1)])
			sel_reg <= sel_reg + 3'(1);
		else if (sel_reg > VALLEY_RST && fb_above_rise_i[sel_reg - 3'(2)])
			sel_reg <= sel_reg - 3'(1);
	end

	// foldback: only from the sixth valley; its own comparator carries hysteresis
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			ff_reg <= 1'b0;
		else if (sel_reg == VALLEY_MAX && fb_below_ff_i)
			ff_reg <= 1'b1;
		else if (!fb_below_ff_i)
			ff_reg <= 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// switching cycle
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_reg <= vllc_pkg::VLLC_C_OFF;
			gate_reg <= 1'b0;
			vcnt_reg <= '0;
		end
		else
		begin
			case (state_reg)
				vllc_pkg::VLLC_C_ON:
				begin
					// turn-off only by the peak current comparator
					if (cs_trip_i)
					begin
						state_reg <= vllc_pkg::VLLC_C_OFF;
						gate_reg <= 1'b0;
						vcnt_reg <= '0;
					end
				end
				vllc_pkg::VLLC_C_OFF:
				begin
					if (valley_evt && vcnt_reg + 3'(1) >= sel_reg)
						state_reg <= ff_reg ? vllc_pkg::VLLC_C_DEAD
							: vllc_pkg::VLLC_C_WAIT;
					else if (minf_hit && demag_done_reg)
						state_reg <= vllc_pkg::VLLC_C_WAIT;
					else if (valley_evt)
						vcnt_reg <= vcnt_reg + 3'(1);
				end
				vllc_pkg::VLLC_C_DEAD:
				begin
					// ramp starts at 0.6 V, so no step on entering foldback
					// a forced cycle still needs a real demag edge, timeouts do not count
					if (fb_above_ramp_i || dt_reg >= DT_CYC || (minf_hit && demag_done_reg))
						state_reg <= vllc_pkg::VLLC_C_WAIT;
				end
				vllc_pkg::VLLC_C_WAIT:
				begin
					if (start_ok)
					begin
						state_reg <= vllc_pkg::VLLC_C_ON;
						gate_reg <= 1'b1;
					end
				end
				default:
				begin
					state_reg <= vllc_pkg::VLLC_C_OFF;
					gate_reg <= 1'b0;
				end
			endcase
		end
	end

	// demag bookkeeping: only a real trip marks the end of demagnetization
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			demag_q_reg <= 1'b0;
			demag_done_reg <= 1'b0;
		end
		else
		begin
			demag_q_reg <= demag_sense_i;
			if (demag_evt && state_reg != vllc_pkg::VLLC_C_ON)
				demag_done_reg <= 1'b1;
			else if (off_evt)
				demag_done_reg <= 1'b0;
		end
	end

	// period counter, saturating so a long skip never wraps
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			per_reg <= '0;
		else if (start_evt)
			per_reg <= '0;
		else if (per_reg != 10'h3ff)
			per_reg <= per_reg + 10'(1);
	end

	// dead-time counter also drives the external ramp reference
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			dt_reg <= '0;
		else if (state_reg == vllc_pkg::VLLC_C_DEAD && dt_reg < DT_CYC)
			dt_reg <= dt_reg + 10'(1);
		else if (state_reg != vllc_pkg::VLLC_C_DEAD)
			dt_reg <= '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// burst phase decision; the 800 mV exit overrides the quiet timer
	always_comb
	begin
		bstate_next = bstate_reg;
		case (bstate_reg)
			vllc_pkg::VLLC_B_OFF:
			begin
				if (fb_below_skip_i)
					bstate_next = vllc_pkg::VLLC_B_STOP;
			end
			vllc_pkg::VLLC_B_STOP:
			begin
				if (fb_above_burst_exit_i)
					bstate_next = vllc_pkg::VLLC_B_OFF;
				else if (fb_above_skip_exit_i && quiet.expired)
					bstate_next = vllc_pkg::VLLC_B_RUN;
			end
			vllc_pkg::VLLC_B_RUN:
			begin
				if (fb_above_burst_exit_i)
					bstate_next = vllc_pkg::VLLC_B_OFF;
				else if (stop_pend_reg && bcnt_reg == BURST_N &&
					state_reg != vllc_pkg::VLLC_C_ON)
					bstate_next = vllc_pkg::VLLC_B_STOP;
			end
			default: bstate_next = vllc_pkg::VLLC_B_OFF;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			bstate_reg <= vllc_pkg::VLLC_B_OFF;
			burst_reg <= 1'b0;
		end
		else
		begin
			bstate_reg <= bstate_next;
			burst_reg <= bstate_next != vllc_pkg::VLLC_B_OFF;
		end
	end

	// burst pulse counter, cleared as each burst resumes
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			bcnt_reg <= '0;
		else if (quiet.start)
			bcnt_reg <= '0;
		else if (start_evt && bstate_reg == vllc_pkg::VLLC_B_RUN && bcnt_reg != BURST_N)
			bcnt_reg <= bcnt_reg + 2'(1);
	end

	// skip-in during a run is remembered; a new skip-in wins over the clear
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			stop_pend_reg <= 1'b0;
		else if (bstate_reg == vllc_pkg::VLLC_B_RUN && fb_below_skip_i)
			stop_pend_reg <= 1'b1;
		else if (bstate_next != vllc_pkg::VLLC_B_RUN)
			stop_pend_reg <= 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flops
	assign gate_drive_o = gate_reg;
	assign valley_sel_o = sel_reg;
	assign foldback_mode_o = ff_reg;
	assign peak_freeze_o = ff_reg;
	assign burst_mode_o = burst_reg;
	assign dt_ramp_o = dt_reg;
	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_burst_stop;
		bstate_reg == vllc_pkg::VLLC_B_RUN ##1 bstate_reg == vllc_pkg::VLLC_B_STOP;
	endsequence
	sequence s_quiet_run;
		bstate_reg == vllc_pkg::VLLC_B_STOP ##1 bstate_reg == vllc_pkg::VLLC_B_RUN;
	endsequence

	a_sel_range: assert property (@(posedge clk_i) disable iff (reset_i)
		valley_sel_o >= VALLEY_RST && valley_sel_o <= VALLEY_MAX)
		else $error("valley selection out of range");
	a_sel_step: assert property (@(posedge clk_i) disable iff (reset_i)
		$changed(valley_sel_o) |-> (valley_sel_o == $past(valley_sel_o) + 3'(1) ||
			valley_sel_o + 3'(1) == $past(valley_sel_o)))
		else $error("valley selection jumped");
	a_ff_entry: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(foldback_mode_o) |-> $past(valley_sel_o) == VALLEY_MAX && peak_freeze_o)
		else $error("foldback entered away from sixth valley");
	a_pulse_whole: assert property (@(posedge clk_i) disable iff (reset_i)
		gate_drive_o && !cs_trip_i |=> gate_drive_o)
		else $error("drive pulse cut short");
	a_max_freq_set_pin_gap: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(gate_drive_o) && !$past(max_freq_set_pin_disable_i) |-> $past(per_reg) >= MAX_FREQ_SET_PIN_CYC)
		else $error("pulse started inside max frequency period");
	a_quiet_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		s_quiet_run |-> $past(quiet.expired) && $past(fb_above_skip_exit_i))
		else $error("burst resumed before quiet timer expiry");
	a_burst_three: assert property (@(posedge clk_i) disable iff (reset_i)
		s_burst_stop |-> $past(bcnt_reg) == BURST_N)
		else $error("burst stopped before three pulses");
	a_burst_exit: assert property (@(posedge clk_i) disable iff (reset_i)
		burst_mode_o && fb_above_burst_exit_i |=> !burst_mode_o)
		else $error("burst mode not left above 800 mV");
	a_dead_cap: assert property (@(posedge clk_i) disable iff (reset_i)
		state_reg == vllc_pkg::VLLC_C_DEAD |-> dt_reg <= DT_CYC ##1
			state_reg != vllc_pkg::VLLC_C_ON)
		else $error("dead-time overran its cap");
	a_minf_force: assert property (@(posedge clk_i) disable iff (reset_i)
		state_reg == vllc_pkg::VLLC_C_OFF && minf_hit && demag_done_reg
		|=> state_reg != vllc_pkg::VLLC_C_OFF)
		else $error("minimum frequency cycle not forced");
endmodule // vllc_ctrl

// ==== dv/vllc_stage_model.sv ====
// flyback stage stand-in: peak current trip and demag ringing valleys
`timescale 1ns/1ps
module vllc_stage_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic gate_drive_i, // gate from the controller
	input int on_len, // on cycles until peak current
	input int demag_len, // cycles from turn-off to first valley
	input int ring_per, // cycles between valleys
	input int n_ring, // valleys seen before ringing is too damped
	output logic cs_trip_o, // peak current reached
	output logic demag_sense_o // demag sense below trigger, a valley
);
	int on_cnt; // cycles since turn-on
	int off_cnt; // cycles since turn-off, saturates
	int rel; // cycles past the first valley
	// reset counts as a turn-off, so the stage rings once and kicks off the first cycle
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			on_cnt <= 0;
			off_cnt <= 0;
		end
		else
		begin
			on_cnt <= gate_drive_i ? on_cnt + 1 : 0;
			off_cnt <= gate_drive_i ? 0 : (off_cnt < 100000 ? off_cnt + 1 : off_cnt);
		end
	end
	// current keeps rising while the switch is on, so the trip holds until turn-off
	assign cs_trip_o = gate_drive_i && (on_cnt >= on_len);
	assign rel = off_cnt - demag_len;
	// two-cycle dips while ringing lasts; the comparator idles low otherwise
	assign demag_sense_o = !gate_drive_i && (rel >= 0) && (rel % ring_per < 2)
		&& (rel / ring_per < n_ring);
endmodule // vllc_stage_model

// ==== dv/tb_valley_lockout_light_load_ctrl.sv ====
// self-checking bench for the light-load gate controller
`timescale 1ns/1ps
module tb_valley_lockout_light_load_ctrl;
	localparam int QUIET = 300; // shortened quiet timer, still longer than a 3-pulse burst
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic max_freq_set_pin_disable_i = 1'b1; // clamp off unless a scenario wants it
	logic soft_start_i = 1'b0;
	logic [4:0] fb_below_fall_i = 5'h00;
	logic [4:0] fb_above_rise_i = 5'h00;
	logic fb_below_ff_i = 1'b0;
	logic fb_above_ramp_i = 1'b1;
	logic fb_below_skip_i = 1'b0;
	logic fb_above_skip_exit_i = 1'b0;
	logic fb_above_burst_exit_i = 1'b0;
	logic demag_sense_i, cs_trip_i, gate_drive_o, foldback_mode_o, peak_freeze_o, burst_mode_o;
	logic [2:0] valley_sel_o;
	logic [9:0] dt_ramp_o;
	int on_len = 5, demag_len = 10, ring_per = 20, n_ring = 6;
	int n_fail = 0, tests_run = 0, cycles = 0;
	always #25 clk_i = ~clk_i;
	vllc_ctrl #(.QUIET_CYC(QUIET), .TW(16)) uut (.clk_i(clk_i), .reset_i(reset_i),
		.max_freq_set_pin_disable_i(max_freq_set_pin_disable_i), .demag_sense_i(demag_sense_i), .cs_trip_i(cs_trip_i),
		.soft_start_i(soft_start_i), .fb_below_fall_i(fb_below_fall_i),
		.fb_above_rise_i(fb_above_rise_i), .fb_below_ff_i(fb_below_ff_i),
		.fb_above_ramp_i(fb_above_ramp_i), .fb_below_skip_i(fb_below_skip_i),
		.fb_above_skip_exit_i(fb_above_skip_exit_i), .fb_above_burst_exit_i(fb_above_burst_exit_i),
		.gate_drive_o(gate_drive_o), .valley_sel_o(valley_sel_o), .foldback_mode_o(foldback_mode_o),
		.peak_freeze_o(peak_freeze_o), .burst_mode_o(burst_mode_o), .dt_ramp_o(dt_ramp_o));
	vllc_stage_model stage (.clk_i(clk_i), .reset_i(reset_i), .gate_drive_i(gate_drive_o),
		.on_len(on_len), .demag_len(demag_len), .ring_per(ring_per), .n_ring(n_ring),
		.cs_trip_o(cs_trip_i), .demag_sense_o(demag_sense_i));
	////////////////////////////////////////
	task automatic chk(input bit ok, input string msg);
		tests_run++;
		if (!ok)
		begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// outputs are read on the falling edge, well clear of the launching edge
	task automatic wait_lvl(input logic v, input int max, output int n);
		n = 0;
		@(negedge clk_i);
		while (gate_drive_o !== v && n < max)
		begin
			@(negedge clk_i);
			n++;
		end
	endtask
	// turn-on to turn-on spacing, less two
	task automatic wait_on(input int max, output int n);
		int m;
		wait_lvl(1'b0, max, m);
		wait_lvl(1'b1, max, n);
		n += m;
	endtask
	// off time of the next full cycle
	task automatic gap(output int n);
		wait_on(2500, n);
		wait_lvl(1'b0, 50, n);
		wait_lvl(1'b1, 2500, n);
	endtask
	task automatic count_rises(input int cyc, output int k);
		logic prev;
		k = 0;
		prev = gate_drive_o;
		repeat (cyc)
		begin
			@(negedge clk_i);
			if (gate_drive_o === 1'b1 && prev !== 1'b1)
				k++;
			prev = gate_drive_o;
		end
	endtask
	// walk the selection one threshold crossing at a time; each crossing moves one valley
	task automatic go_sel(input int s);
		int old;
		while (int'(valley_sel_o) != s)
		begin
			old = valley_sel_o;
			@(posedge clk_i);
			if (old < s)
				fb_below_fall_i <= 5'h1f;
			else
				fb_above_rise_i <= 5'h1f;
			@(posedge clk_i);
			fb_below_fall_i <= 5'h00;
			fb_above_rise_i <= 5'h00;
			@(negedge clk_i);
			chk(valley_sel_o === 3'(old < s ? old + 1 : old - 1), "valley step");
		end
	endtask
	////////////////////////////////////////
	task automatic t_hold();
		go_sel(2);
		@(posedge clk_i);
		// every bit but the two that belong to valley two (fall index 1, rise index 0)
		fb_below_fall_i <= 5'h1d;
		fb_above_rise_i <= 5'h1e;
		repeat (10) @(posedge clk_i);
		fb_below_fall_i <= 5'h00;
		fb_above_rise_i <= 5'h00;
		@(negedge clk_i);
		chk(valley_sel_o === 3'h2, "foreign threshold moved valley");
	endtask
	task automatic t_count();
		int n;
		go_sel(3);
		gap(n);
		chk(n >= 48 && n <= 56, "third valley turn-on");
	endtask
	// rows: damped ringing at valley 5, no ringing, no ringing during soft-start
	task automatic t_timeout();
		int sel_t[3] = '{5, 1, 1};
		int ring_t[3] = '{3, 0, 0};
		int lo_t[3] = '{283, 115, 1990};
		int hi_t[3] = '{302, 130, 2015};
		int n;
		for (int i = 0; i < 3; i++)
		begin
			go_sel(sel_t[i]);
			@(posedge clk_i);
			n_ring <= ring_t[i];
			soft_start_i <= (i == 2);
			gap(n);
			chk(n >= lo_t[i] && n <= hi_t[i], "valley timeout spacing");
		end
		@(posedge clk_i);
		soft_start_i <= 1'b0;
		n_ring <= 6;
	endtask
	task automatic t_max_freq_set_pin();
		int n;
		go_sel(1);
		@(posedge clk_i);
		max_freq_set_pin_disable_i <= 1'b0;
		wait_on(400, n);
		wait_on(400, n);
		chk(n >= 178 && n <= 188, "max frequency spacing");
		@(posedge clk_i);
		max_freq_set_pin_disable_i <= 1'b1;
		wait_on(400, n);
		wait_on(400, n);
		chk(n < 40, "clamp not disabled");
	endtask
	task automatic t_foldback();
		int n;
		go_sel(6);
		@(posedge clk_i);
		fb_below_ff_i <= 1'b1;
		@(posedge clk_i);
		@(negedge clk_i);
		chk(foldback_mode_o === 1'b1 && peak_freeze_o === 1'b1, "foldback entry");
		gap(n);
		chk(n >= 104 && n <= 122, "dead-time at ramp start");
		@(posedge clk_i);
		fb_above_ramp_i <= 1'b0;
		gap(n);
		chk(n >= 745 && n <= 770, "full dead-time");
		// one late valley and the long timeout: the period clamp fires in the off-time
		@(posedge clk_i);
		demag_len <= 300;
		n_ring <= 1;
		soft_start_i <= 1'b1;
		wait_on(2000, n);
		wait_on(2000, n);
		chk(n >= 793 && n <= 806, "forced cycle period");
		@(posedge clk_i);
		soft_start_i <= 1'b0;
		demag_len <= 10;
		n_ring <= 0;
		gap(n);
		chk(n > 900 && n < 1500, "forced cycle without demag");
		@(posedge clk_i);
		n_ring <= 6;
		fb_above_ramp_i <= 1'b1;
		fb_below_ff_i <= 1'b0;
		go_sel(1);
	endtask
	// quiet timer starts expired, each run start reloads it
	task automatic t_burst();
		int n, k;
		wait_lvl(1'b1, 100, n);
		@(posedge clk_i);
		fb_below_skip_i <= 1'b1;
		wait_lvl(1'b0, 50, n);
		chk(n >= 3, "pulse cut short");
		count_rises(200, k);
		chk(k == 0 && burst_mode_o === 1'b1, "skip did not stop");
		@(posedge clk_i);
		fb_below_skip_i <= 1'b0;
		fb_above_skip_exit_i <= 1'b1;
		wait_lvl(1'b1, 60, n);
		chk(n < 60 && burst_mode_o === 1'b1, "no resume in burst");
		@(posedge clk_i);
		fb_above_skip_exit_i <= 1'b0;
		fb_below_skip_i <= 1'b1;
		count_rises(120, k);
		chk(k == 2, "burst pulse count");
		@(posedge clk_i);
		fb_below_skip_i <= 1'b0;
		fb_above_skip_exit_i <= 1'b1;
		count_rises(120, k);
		chk(k == 0, "restart before quiet expiry");
		wait_lvl(1'b1, 150, n);
		chk(n < 150, "no restart after expiry");
		@(posedge clk_i);
		fb_above_skip_exit_i <= 1'b0;
		fb_below_skip_i <= 1'b1;
		count_rises(100, k);
		@(posedge clk_i);
		fb_below_skip_i <= 1'b0;
		count_rises(400, k);
		chk(k == 0, "timer alone restarted");
		@(posedge clk_i);
		fb_above_skip_exit_i <= 1'b1;
		wait_lvl(1'b1, 60, n);
		chk(n < 60, "skip exit ignored");
		@(posedge clk_i);
		fb_above_skip_exit_i <= 1'b0;
		fb_below_skip_i <= 1'b1;
		count_rises(100, k);
		@(posedge clk_i);
		fb_below_skip_i <= 1'b0;
		fb_above_burst_exit_i <= 1'b1;
		wait_lvl(1'b1, 60, n);
		chk(n < 60 && burst_mode_o === 1'b0, "burst exit");
		@(posedge clk_i);
		fb_above_burst_exit_i <= 1'b0;
	endtask
	////////////////////////////////////////
	// hang guard, about three times the expected run
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_fail++;
			$display("[FAIL] %0t watchdog", $time);
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		@(negedge clk_i);
		chk(gate_drive_o === 1'b0 && valley_sel_o === 3'h1 && burst_mode_o === 1'b0
			&& peak_freeze_o === 1'b0 && dt_ramp_o === 10'h000, "reset state");
		t_hold();
		t_count();
		t_timeout();
		t_max_freq_set_pin();
		t_foldback();
		t_burst();
		tally_and_finish();
	end
endmodule // tb_valley_lockout_light_load_ctrl
